/* File: src/dswc_top.v */
// Dormant state wakeup controller with AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "dswc_defs.vh"
module dswc_top #(
   parameter ANA_W = 12,
   parameter BOOT_CYC = 16
) (
   // Clock, reset, enable
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   // External pins, asynchronous except wake_analog_a_ready
   input wire pwr_key_n,
   input wire ext_rst_n,
   input wire wake_gpio_a,
   input wire wake_gpio_b,
   input wire wake_analog_a_ready,
   // Analog samples, same clock
   input wire [ANA_W-1:0] wake_analog_a,
   input wire [ANA_W-1:0] wake_analog_b,
   // Power control
   output reg core_pwr_on,
   output reg core_rst,
   output reg emerg_off,
   output reg dormant,
   output reg irq,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam S_POR = 5'b00001;
   localparam S_BOOT = 5'b00010;
   localparam S_ACTIVE = 5'b00100;
   localparam S_DORMANT = 5'b01000;
   localparam S_OFF = 5'b10000;

   // Three-stage synchronisers; change accepted when stages two and three agree
   reg [2:0] key_s_reg, rst_s_reg, ga_s_reg, gb_s_reg;
   reg key_reg, rstin_reg, ga_reg, gb_reg;
   always @(posedge clk) begin
      if (sys_rst) begin
         key_s_reg <= 3'h7;
         rst_s_reg <= 3'h7;
         ga_s_reg <= 3'h0;
         gb_s_reg <= 3'h0;
         key_reg <= 1'b0;
         rstin_reg <= 1'b0;
         ga_reg <= 1'b0;
         gb_reg <= 1'b0;
      end else if (clk_en) begin
         key_s_reg <= {key_s_reg[1:0], pwr_key_n};
         rst_s_reg <= {rst_s_reg[1:0], ext_rst_n};
         ga_s_reg <= {ga_s_reg[1:0], wake_gpio_a};
         gb_s_reg <= {gb_s_reg[1:0], wake_gpio_b};
         if (key_s_reg[1] == key_s_reg[2])
            key_reg <= ~key_s_reg[2];
         if (rst_s_reg[1] == rst_s_reg[2])
            rstin_reg <= ~rst_s_reg[2];
         if (ga_s_reg[1] == ga_s_reg[2])
            ga_reg <= ga_s_reg[2];
         if (gb_s_reg[1] == gb_s_reg[2])
            gb_reg <= gb_s_reg[2];
      end
   end

   // Registers
   reg [2:0] ctrl_reg;
   reg [31:0] upd_reg, wtmr_reg, act_reg;
   reg [`DSWC_SRC_N-1:0] wen_reg, cause_reg;
   reg [3:0] ana_cfg_reg;
   reg [2*ANA_W-1:0] ana_a_lim_reg, ana_b_lim_reg;
   reg [5:0] gpio_cfg_reg;
   reg [`DSWC_IRQ_N-1:0] irq_stat_reg, irq_en_reg;
   reg [4:0] state_reg;
   reg [31:0] upd_cnt_reg, wt_cnt_reg, act_cnt_reg;
   reg [7:0] boot_cnt_reg;
   reg ga_d_reg, gb_d_reg, key_d_reg, rstin_d_reg, primed_reg;

   wire mode_net = ctrl_reg[`DSWC_CTRL_MODE];
   // Wakeup timer: derived from update timer in network mode
   wire [31:0] wt_load = mode_net ? ((upd_reg > `DSWC_WT_LEAD) ? upd_reg - `DSWC_WT_LEAD : 32'h1)
      : wtmr_reg;
   wire wt_on = mode_net | ctrl_reg[`DSWC_CTRL_WT_EN];

   function ana_hit;
      input [1:0] md;
      input [ANA_W-1:0] v;
      input [2*ANA_W-1:0] lim;
      reg [ANA_W-1:0] lo, hi;
      begin
         lo = lim[ANA_W-1:0];
         hi = lim[2*ANA_W-1:ANA_W];
         case (md)
            `DSWC_ANA_ABOVE: ana_hit = v > lo;
            `DSWC_ANA_BELOW: ana_hit = v < lo;
            `DSWC_ANA_INSIDE: ana_hit = (v >= lo) && (v <= hi);
            default: ana_hit = (v < lo) || (v > hi);
         endcase
      end
   endfunction

   function gp_hit;
      input [2:0] md;
      input cur, prev;
      begin
         case (md)
            `DSWC_GP_HIGH: gp_hit = cur;
            `DSWC_GP_LOW: gp_hit = ~cur;
            `DSWC_GP_RISE: gp_hit = cur & ~prev;
            `DSWC_GP_FALL: gp_hit = ~cur & prev;
            `DSWC_GP_BOTH: gp_hit = cur ^ prev;
            default: gp_hit = 1'b0;
         endcase
      end
   endfunction

   // Raw source conditions, gated by per-source enables
   reg [`DSWC_SRC_N-1:0] src;
   always @* begin
      src = {`DSWC_SRC_N{1'b0}};
      src[`DSWC_SRC_UPD] = mode_net && (upd_cnt_reg == 32'h1);
      src[`DSWC_SRC_WTMR] = wt_on && (wt_cnt_reg == 32'h1);
      src[`DSWC_SRC_ANA_A] = wake_analog_a_ready && ana_hit(ana_cfg_reg[1:0], wake_analog_a, ana_a_lim_reg);
      src[`DSWC_SRC_ANA_B] = wake_analog_a_ready && ana_hit(ana_cfg_reg[3:2], wake_analog_b, ana_b_lim_reg);
      src[`DSWC_SRC_GPIO_A] = primed_reg && gp_hit(gpio_cfg_reg[2:0], ga_reg, ga_d_reg);
      src[`DSWC_SRC_GPIO_B] = primed_reg && gp_hit(gpio_cfg_reg[5:3], gb_reg, gb_d_reg);
      src[`DSWC_SRC_RESET] = rstin_reg & ~rstin_d_reg & key_reg;
      src[`DSWC_SRC_KEY] = key_reg & ~key_d_reg;
   end
   wire [`DSWC_SRC_N-1:0] wake_vec = src & wen_reg;
   wire emerg = rstin_reg & ~rstin_d_reg & ~key_reg;

   // AXI4-Lite
   reg aw_hold_reg, w_hold_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   wire aw_have = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
   wire w_have = w_hold_reg | (s_axi_wvalid & s_axi_wready);
   wire [7:0] wa = aw_hold_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0] wd = w_hold_reg ? w_data_reg : s_axi_wdata;
   wire [3:0] ws = w_hold_reg ? w_strb_reg : s_axi_wstrb;
   wire wr_go = aw_have & w_have & ~s_axi_bvalid;
   wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
   reg wr_ok;
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      case (wa)
         `DSWC_CTRL_OFF, `DSWC_UPD_OFF, `DSWC_WTMR_OFF, `DSWC_WEN_OFF, `DSWC_ANA_CFG_OFF,
         `DSWC_ANA_A_LIM_OFF, `DSWC_ANA_B_LIM_OFF, `DSWC_GPIO_CFG_OFF, `DSWC_IRQ_EN_OFF,
         `DSWC_IRQ_CLR_OFF, `DSWC_ACT_OFF: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `DSWC_CTRL_OFF: rd_val = {29'h0, ctrl_reg};
         `DSWC_STAT_OFF: rd_val = {27'h0, state_reg};
         `DSWC_UPD_OFF: rd_val = upd_reg;
         `DSWC_WTMR_OFF: rd_val = wtmr_reg;
         `DSWC_WEN_OFF: rd_val = {24'h0, wen_reg};
         `DSWC_ANA_CFG_OFF: rd_val = {28'h0, ana_cfg_reg};
         `DSWC_ANA_A_LIM_OFF: rd_val = {{(32-2*ANA_W){1'b0}}, ana_a_lim_reg};
         `DSWC_ANA_B_LIM_OFF: rd_val = {{(32-2*ANA_W){1'b0}}, ana_b_lim_reg};
         `DSWC_GPIO_CFG_OFF: rd_val = {26'h0, gpio_cfg_reg};
         `DSWC_CAUSE_OFF: rd_val = {24'h0, cause_reg};
         `DSWC_IRQ_STAT_OFF: rd_val = {23'h0, irq_stat_reg};
         `DSWC_IRQ_EN_OFF: rd_val = {23'h0, irq_en_reg};
         `DSWC_ACT_OFF: rd_val = act_reg;
         default: begin
            rd_val = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end
   wire wr_ctrl = wr_go && wr_ok && (wa == `DSWC_CTRL_OFF);

   always @(posedge clk) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DSWC_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `DSWC_RESP_OK;
         s_axi_rdata <= 32'h0;
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         ctrl_reg <= 3'h0;
         upd_reg <= `DSWC_UPD_RST;
         wtmr_reg <= `DSWC_WTMR_RST;
         act_reg <= `DSWC_ACT_RST;
         wen_reg <= {`DSWC_SRC_N{1'b1}};
         ana_cfg_reg <= 4'h0;
         ana_a_lim_reg <= {2*ANA_W{1'b1}};
         ana_b_lim_reg <= {2*ANA_W{1'b1}};
         gpio_cfg_reg <= 6'h0;
         irq_en_reg <= {`DSWC_IRQ_N{1'b0}};
      end else if (clk_en) begin
         s_axi_awready <= ~aw_have & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_have & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready & ~wr_go) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready & ~wr_go) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `DSWC_RESP_OK : `DSWC_RESP_SLVERR;
            case (wa)
               `DSWC_CTRL_OFF: ctrl_reg <= (ctrl_reg & ~wmask[2:0]) | (wd[2:0] & wmask[2:0]);
               `DSWC_UPD_OFF: upd_reg <= (upd_reg & ~wmask) | (wd & wmask);
               `DSWC_WTMR_OFF: wtmr_reg <= (wtmr_reg & ~wmask) | (wd & wmask);
               `DSWC_ACT_OFF: act_reg <= (act_reg & ~wmask) | (wd & wmask);
               `DSWC_WEN_OFF: if (ws[0]) wen_reg <= wd[`DSWC_SRC_N-1:0];
               `DSWC_ANA_CFG_OFF: if (ws[0]) ana_cfg_reg <= wd[3:0];
               `DSWC_ANA_A_LIM_OFF: ana_a_lim_reg <= wd[2*ANA_W-1:0];
               `DSWC_ANA_B_LIM_OFF: ana_b_lim_reg <= wd[2*ANA_W-1:0];
               `DSWC_GPIO_CFG_OFF: if (ws[0]) gpio_cfg_reg <= wd[5:0];
               `DSWC_IRQ_EN_OFF: irq_en_reg <= wd[`DSWC_IRQ_N-1:0];
               default: ;
            endcase
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Sleep request bit self-clears once taken
         if (state_reg == S_ACTIVE && ctrl_reg[`DSWC_CTRL_SLEEP] && !wr_ctrl)
            ctrl_reg[`DSWC_CTRL_SLEEP] <= 1'b0;
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_ok ? `DSWC_RESP_OK : `DSWC_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Power state machine; core held in reset while booting
   wire boot_done = (boot_cnt_reg == BOOT_CYC[7:0]);
   wire irq_clr_wr = wr_go && (wa == `DSWC_IRQ_CLR_OFF) && ws[0];
   // Clear and wake in one cycle: other bits clear, the new wake bits still land
   wire [`DSWC_IRQ_N-1:0] irq_kept = irq_clr_wr ? (irq_stat_reg & ~wd[`DSWC_IRQ_N-1:0]) : irq_stat_reg;
   always @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= S_POR;
         upd_cnt_reg <= 32'h0;
         wt_cnt_reg <= 32'h0;
         act_cnt_reg <= 32'h0;
         boot_cnt_reg <= 8'h0;
         cause_reg <= {`DSWC_SRC_N{1'b0}};
         irq_stat_reg <= {`DSWC_IRQ_N{1'b0}};
         ga_d_reg <= 1'b0;
         gb_d_reg <= 1'b0;
         key_d_reg <= 1'b0;
         rstin_d_reg <= 1'b0;
         primed_reg <= 1'b0;
         core_pwr_on <= 1'b0;
         core_rst <= 1'b1;
         emerg_off <= 1'b0;
         dormant <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         ga_d_reg <= ga_reg;
         gb_d_reg <= gb_reg;
         key_d_reg <= key_reg;
         rstin_d_reg <= rstin_reg;
         primed_reg <= 1'b1;
         if (irq_clr_wr)
            irq_stat_reg <= irq_kept;
         if (upd_cnt_reg > 32'h1)
            upd_cnt_reg <= upd_cnt_reg - 32'h1;
         if (wt_cnt_reg > 32'h1)
            wt_cnt_reg <= wt_cnt_reg - 32'h1;
         case (state_reg)
            S_POR: begin
               // Wait for key synchroniser to settle before deciding
               if (boot_done) begin
                  boot_cnt_reg <= 8'h0;
                  state_reg <= key_reg ? S_BOOT : S_DORMANT;
                  if (!key_reg) begin
                     upd_cnt_reg <= upd_reg;
                     wt_cnt_reg <= wt_load;
                  end
               end else begin
                  boot_cnt_reg <= boot_cnt_reg + 8'h1;
               end
            end
            S_BOOT: begin
               core_pwr_on <= 1'b1;
               core_rst <= 1'b1;
               dormant <= 1'b0;
               if (boot_done) begin
                  boot_cnt_reg <= 8'h0;
                  core_rst <= 1'b0;
                  state_reg <= S_ACTIVE;
                  act_cnt_reg <= act_reg;
               end else begin
                  boot_cnt_reg <= boot_cnt_reg + 8'h1;
               end
            end
            S_ACTIVE: begin
               if (act_cnt_reg != 32'h0)
                  act_cnt_reg <= act_cnt_reg - 32'h1;
               if (emerg) begin
                  state_reg <= S_OFF;
               end else if (src[`DSWC_SRC_RESET]) begin
                  state_reg <= S_BOOT;
                  cause_reg <= 8'h1 << `DSWC_SRC_RESET;
               end else if (ctrl_reg[`DSWC_CTRL_SLEEP] || (mode_net && act_cnt_reg == 32'h0)) begin
                  state_reg <= S_DORMANT;
                  upd_cnt_reg <= upd_reg;
                  wt_cnt_reg <= wt_on ? wt_load : 32'h0;
               end
            end
            S_DORMANT: begin
               core_pwr_on <= 1'b0;
               core_rst <= 1'b1;
               dormant <= 1'b1;
               if (emerg) begin
                  state_reg <= S_OFF;
               end else if (wake_vec != {`DSWC_SRC_N{1'b0}}) begin
                  state_reg <= S_BOOT;
                  boot_cnt_reg <= 8'h0;
                  cause_reg <= wake_vec;
                  irq_stat_reg <= irq_kept | {1'b0, wake_vec};
               end
            end
            S_OFF: begin
               core_pwr_on <= 1'b0;
               core_rst <= 1'b1;
               dormant <= 1'b0;
               emerg_off <= 1'b1;
               irq_stat_reg[`DSWC_IRQ_OFF_EV] <= 1'b1;
            end
            default: state_reg <= S_POR;
         endcase
         irq <= |(irq_stat_reg & irq_en_reg);
      end
   end
endmodule // dswc_top

/* File: src/dswc_defs.vh */
// Constants for the dormant state wakeup controller
`ifndef DSWC_DEFS_VH
`define DSWC_DEFS_VH
// Register byte offsets
`define DSWC_CTRL_OFF 8'h00
`define DSWC_STAT_OFF 8'h04
`define DSWC_UPD_OFF 8'h08
`define DSWC_WTMR_OFF 8'h0c
`define DSWC_WEN_OFF 8'h10
`define DSWC_ANA_CFG_OFF 8'h14
`define DSWC_ANA_A_LIM_OFF 8'h18
`define DSWC_ANA_B_LIM_OFF 8'h1c
`define DSWC_GPIO_CFG_OFF 8'h20
`define DSWC_CAUSE_OFF 8'h24
`define DSWC_IRQ_STAT_OFF 8'h28
`define DSWC_IRQ_EN_OFF 8'h2c
`define DSWC_IRQ_CLR_OFF 8'h30
`define DSWC_ACT_OFF 8'h34
// CTRL fields
`define DSWC_CTRL_SLEEP 0
`define DSWC_CTRL_MODE 1
`define DSWC_CTRL_WT_EN 2
// Wake source bit positions (enable, cause, irq)
`define DSWC_SRC_UPD 0
`define DSWC_SRC_WTMR 1
`define DSWC_SRC_ANA_A 2
`define DSWC_SRC_ANA_B 3
`define DSWC_SRC_GPIO_A 4
`define DSWC_SRC_GPIO_B 5
`define DSWC_SRC_RESET 6
`define DSWC_SRC_KEY 7
`define DSWC_SRC_N 8
`define DSWC_IRQ_OFF_EV 8
`define DSWC_IRQ_N 9
// Register reset values, in ticks
`define DSWC_UPD_RST 32'h0000_1000
`define DSWC_WTMR_RST 32'h0000_0800
`define DSWC_ACT_RST 32'h0000_0100
// Wakeup timer lead over update timer, in ticks
`define DSWC_WT_LEAD 32'h0000_0010
// Analog mode codes
`define DSWC_ANA_ABOVE 2'h0
`define DSWC_ANA_BELOW 2'h1
`define DSWC_ANA_INSIDE 2'h2
`define DSWC_ANA_OUTSIDE 2'h3
// GPIO mode codes
`define DSWC_GP_HIGH 3'h0
`define DSWC_GP_LOW 3'h1
`define DSWC_GP_RISE 3'h2
`define DSWC_GP_FALL 3'h3
`define DSWC_GP_BOTH 3'h4
// AXI responses
`define DSWC_RESP_OK 2'h0
`define DSWC_RESP_SLVERR 2'h2
`endif

/* File: dv/dswc_asserts.sv */
// Port assertions for the dormant state wakeup controller
`timescale 1ns/100ps
module dswc_asserts #(parameter BOOT_CYC = 16) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   input wire clk_en,
   // Power control
   input wire core_pwr_on,
   input wire core_rst,
   input wire emerg_off,
   input wire dormant,
   input wire irq,
   // AXI answers
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   // POR plus boot, with slack for the input synchronisers
   localparam int WK = 4 * BOOT_CYC + 40;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rst;
      disable iff (1'h0) sys_rst && clk_en |=> !core_pwr_on && core_rst && !dormant && !emerg_off && !irq;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset values");
   property p_boot_done;
      $fell(core_rst) |-> core_pwr_on && !dormant;
   endproperty
   a_boot_done: assert property (p_boot_done) else $error("core left reset while unpowered");
   property p_wake;
      $fell(dormant) |-> ##[1:WK] ((core_pwr_on && !core_rst) || emerg_off);
   endproperty
   a_wake: assert property (p_wake) else $error("no reboot after leaving dormancy");
   property p_dorm_off;
      dormant |-> !core_pwr_on;
   endproperty
   a_dorm_off: assert property (p_dorm_off) else $error("core powered while dormant");
   property p_eoff_stick;
      emerg_off |=> emerg_off;
   endproperty
   a_eoff_stick: assert property (p_eoff_stick) else $error("emergency off released");
   property p_eoff_pwr;
      $rose(emerg_off) |-> ##[0:4] (!core_pwr_on && !dormant);
   endproperty
   a_eoff_pwr: assert property (p_eoff_pwr) else $error("power kept after emergency off");
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped early");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped early");
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
endmodule // dswc_asserts
bind dswc_top dswc_asserts #(.BOOT_CYC(BOOT_CYC)) dswc_asserts_i (.clk, .sys_rst, .clk_en, .core_pwr_on,
   .core_rst, .emerg_off, .dormant, .irq, .s_axi_arvalid, .s_axi_arready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

/* File: dv/dswc_pins.sv */
// Model of the external wake pins
`timescale 1ns/100ps
module dswc_pins #(parameter ANA_W = 12) (
   // Clock
   input wire clk,
   // Pins
   output reg pwr_key_n,
   output reg ext_rst_n,
   output reg wake_gpio_a,
   output reg wake_gpio_b,
   output reg wake_analog_a_ready,
   output reg [ANA_W-1:0] wake_analog_a,
   output reg [ANA_W-1:0] wake_analog_b
);
   initial begin
      pwr_key_n = 1'h0;
      ext_rst_n = 1'h1;
      wake_gpio_a = 1'h0;
      wake_gpio_b = 1'h0;
      wake_analog_a_ready = 1'h1;
      wake_analog_a = 12'h000;
      wake_analog_b = 12'h000;
   end
   task key(input v); begin
      @(posedge clk);
      pwr_key_n <= v;
   end endtask
   task xrst(input v); begin
      @(posedge clk);
      ext_rst_n <= v;
   end endtask
   task gp(input a, input b); begin
      @(posedge clk);
      wake_gpio_a <= a;
      wake_gpio_b <= b;
   end endtask
   task ana(input [ANA_W-1:0] a); begin
      @(posedge clk);
      wake_analog_a <= a;
   end endtask
   task anb(input [ANA_W-1:0] b); begin
      @(posedge clk);
      wake_analog_b <= b;
   end endtask
endmodule // dswc_pins

/* File: dv/dswc_top_tb.sv */
// Register-level testbench for the dormant state wakeup controller
`timescale 1ns/100ps
`include "dswc_defs.vh"
module dswc_top_tb;
   // Quiet levels per GPIO mode, analog quiet and trigger samples per mode
   localparam [4:0] GQ = 5'h1a;
   localparam [47:0] AQ = {12'h200, 12'h400, 12'h200, 12'h050};
   localparam [47:0] AT = {12'h400, 12'h200, 12'h050, 12'h200};
   reg clk = 1'h0;
   reg sys_rst = 1'h1;
   reg clk_en = 1'h1;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg [7:0] s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   wire pwr_key_n, ext_rst_n, wake_gpio_a, wake_gpio_b, wake_analog_a_ready;
   wire [11:0] wake_analog_a, wake_analog_b;
   wire core_pwr_on, core_rst, emerg_off, dormant, irq;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   reg [31:0] d;
   reg [1:0] rr;
   integer num_errors = 0, comparisons = 0, i;
   always #25 clk = ~clk;
   dswc_top dswc_top_i (.*);
   dswc_pins dswc_pins_i (.*);
   task results; begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   end endtask
   task chk(input [31:0] got, input [31:0] exp); begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end endtask
   task wr(input [7:0] a, input [31:0] v, input [1:0] r);
      reg aw, w;
      begin
         @(posedge clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         aw = 1'h0;
         w = 1'h0;
         while (!(aw && w)) begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) aw = 1'h1;
            if (s_axi_wready === 1'h1) w = 1'h1;
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
         end
         while (s_axi_bvalid !== 1'h1) @(posedge clk);
         // Late ready keeps the response standing for a cycle
         s_axi_bready <= 1'h1;
         @(posedge clk);
         s_axi_bready <= 1'h0;
         chk(s_axi_bresp, r);
      end
   endtask
   task rd(input [7:0] a); begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      while (s_axi_rvalid !== 1'h1) @(posedge clk);
      s_axi_rready <= 1'h1;
      @(posedge clk);
      s_axi_rready <= 1'h0;
      d = s_axi_rdata;
      rr = s_axi_rresp;
   end endtask
   task wait_st(input v); begin
      while (v ? dormant !== 1'h1 : !(dormant === 1'h0 && core_rst === 1'h0)) @(posedge clk);
   end endtask
   task nap(input [31:0] c, input [31:0] en); begin
      wr(`DSWC_WEN_OFF, en, `DSWC_RESP_OK);
      wr(`DSWC_CTRL_OFF, c, `DSWC_RESP_OK);
      wait_st(1'h1);
      repeat (40) @(posedge clk);
      chk(dormant, 1'h1);
      rd(`DSWC_STAT_OFF);
      chk(d, 32'h8);
   end endtask
   task woke(input [31:0] c); begin
      wait_st(1'h0);
      rd(`DSWC_CAUSE_OFF);
      chk(d, c);
   end endtask
   initial begin
      #(50 * 40000);
      num_errors = num_errors + 1;
      results;
   end
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'h0;
      wait_st(1'h0);
      rd(`DSWC_STAT_OFF);
      chk(d, 32'h4);
      rd(`DSWC_UPD_OFF);
      chk(d, `DSWC_UPD_RST);
      // Byte strobe: only the low byte may change
      s_axi_wstrb <= 4'h1;
      wr(`DSWC_UPD_OFF, 32'h0000_20cc, `DSWC_RESP_OK);
      s_axi_wstrb <= 4'hf;
      rd(`DSWC_UPD_OFF);
      chk(d, 32'h0000_10cc);
      rd(`DSWC_WTMR_OFF);
      chk(d, `DSWC_WTMR_RST);
      rd(`DSWC_WEN_OFF);
      chk(d, 32'hff);
      rd(8'h40);
      chk({rr, d}, {`DSWC_RESP_SLVERR, 32'h0});
      wr(`DSWC_STAT_OFF, 32'h0, `DSWC_RESP_SLVERR);
      nap(32'h1, 32'h40);
      dswc_pins_i.xrst(1'h0);
      repeat (8) @(posedge clk);
      dswc_pins_i.xrst(1'h1);
      woke(32'h40);
      dswc_pins_i.key(1'h1);
      nap(32'h1, 32'h80);
      dswc_pins_i.key(1'h0);
      woke(32'h80);
      dswc_pins_i.key(1'h1);
      for (i = 0; i < 5; i = i + 1) begin
         wr(`DSWC_GPIO_CFG_OFF, i, `DSWC_RESP_OK);
         dswc_pins_i.gp(GQ[i], 1'h1);
         nap(32'h1, 32'h10);
         dswc_pins_i.gp(~GQ[i], 1'h1);
         woke(32'h10);
      end
      wr(`DSWC_ANA_A_LIM_OFF, 32'h0030_0100, `DSWC_RESP_OK);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`DSWC_ANA_CFG_OFF, i, `DSWC_RESP_OK);
         dswc_pins_i.ana(AQ[i*12 +: 12]);
         nap(32'h1, 32'h04);
         dswc_pins_i.ana(AT[i*12 +: 12]);
         woke(32'h04);
      end
      wr(`DSWC_ANA_B_LIM_OFF, 32'h0000_0100, `DSWC_RESP_OK);
      wr(`DSWC_ANA_CFG_OFF, 32'h0, `DSWC_RESP_OK);
      nap(32'h1, 32'h08);
      dswc_pins_i.anb(12'h200);
      woke(32'h08);
      wr(`DSWC_IRQ_CLR_OFF, 32'h1ff, `DSWC_RESP_OK);
      wr(`DSWC_WTMR_OFF, 32'h100, `DSWC_RESP_OK);
      wr(`DSWC_IRQ_EN_OFF, 32'h2, `DSWC_RESP_OK);
      nap(32'h5, 32'h02);
      woke(32'h02);
      chk(irq, 1'h1);
      wr(`DSWC_IRQ_EN_OFF, 32'h0, `DSWC_RESP_OK);
      repeat (2) @(posedge clk);
      chk(irq, 1'h0);
      wr(`DSWC_IRQ_EN_OFF, 32'h2, `DSWC_RESP_OK);
      repeat (2) @(posedge clk);
      chk(irq, 1'h1);
      wr(`DSWC_IRQ_CLR_OFF, 32'h2, `DSWC_RESP_OK);
      repeat (2) @(posedge clk);
      chk(irq, 1'h0);
      wr(`DSWC_UPD_OFF, 32'h80, `DSWC_RESP_OK);
      wr(`DSWC_ACT_OFF, 32'h40, `DSWC_RESP_OK);
      nap(32'h3, 32'h03);
      woke(32'h02);
      wait_st(1'h1);
      wr(`DSWC_WEN_OFF, 32'h01, `DSWC_RESP_OK);
      woke(32'h01);
      wr(`DSWC_GPIO_CFG_OFF, 32'h2, `DSWC_RESP_OK);
      dswc_pins_i.gp(1'h0, 1'h1);
      wr(`DSWC_WEN_OFF, 32'h11, `DSWC_RESP_OK);
      wait_st(1'h1);
      dswc_pins_i.gp(1'h1, 1'h1);
      woke(32'h10);
      // A high pin would wake at once after reset in default level mode
      dswc_pins_i.gp(1'h0, 1'h0);
      wr(`DSWC_CTRL_OFF, 32'h0, `DSWC_RESP_OK);
      sys_rst <= 1'h1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'h0;
      wait_st(1'h1);
      rd(`DSWC_STAT_OFF);
      chk(d, 32'h8);
      // Frozen clock enable must hold off the emergency off
      clk_en <= 1'h0;
      dswc_pins_i.xrst(1'h0);
      repeat (10) @(posedge clk);
      chk({emerg_off, dormant}, 2'h1);
      clk_en <= 1'h1;
      while (emerg_off !== 1'h1) @(posedge clk);
      rd(`DSWC_STAT_OFF);
      chk(d, 32'h10);
      results;
   end
endmodule // dswc_top_tb
